/* tsdp_pkg.sv */
// constants and types shared by the two-wire serial debug port
package tsdp_pkg;

  // ==========================================================================
  // register bus map (byte addresses, one 32-bit word each)
  localparam logic [3:0] TSDP_OFS_CTRL   = 4'h0;
  localparam logic [3:0] TSDP_OFS_STATUS = 4'h4;
  localparam logic [3:0] TSDP_OFS_ACTIV  = 4'h8;

  // control word fields
  localparam int TSDP_CTRL_PERMIT_BIT = 0;
  localparam int TSDP_CTRL_HALT_BIT   = 1;
  localparam int TSDP_CTRL_CLEAR_BIT  = 2;

  // status word fields
  localparam int TSDP_ST_GRANT_BIT  = 0;
  localparam int TSDP_ST_ACTIVE_BIT = 1;
  localparam int TSDP_ST_READ_BIT   = 2;
  localparam int TSDP_ST_SEP_BIT    = 3;
  localparam int TSDP_ST_OE_BIT     = 4;
  localparam int TSDP_ST_ADDR_LSB   = 8;
  localparam int TSDP_ST_LASTW_LSB  = 16;

  // activity word fields
  localparam int TSDP_ACT_BYTES_LSB = 0;
  localparam int TSDP_ACT_START_LSB = 16;

  // reset values of software-visible control bits
  localparam logic TSDP_RST_PERMIT = 1'b0;
  localparam logic TSDP_RST_HALT   = 1'b0;

  // ==========================================================================
  // serial register spaces
  localparam logic [6:0] TSDP_WR_LAST_ADDR  = 7'h30;
  localparam logic [6:0] TSDP_RD_LAST_ADDR  = 7'h20;
  localparam logic [6:0] TSDP_BUS_STAT_ADDR = 7'h17;

  // bit counts per byte on the link
  localparam logic [3:0] TSDP_DATA_BITS = 4'h8;
  localparam logic [3:0] TSDP_LAST_DATA = 4'h7;
  localparam logic [3:0] TSDP_SEP_SLOT  = 4'h8;

  // ==========================================================================
  // serial command phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_WRITE,
    PH_READ
  } tsdp_phase_t;

endpackage

/* tsdp_serial_debug_port.sv */
// two-wire serial debug port slave with avalon-mm control registers
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module tsdp_serial_debug_port
  import tsdp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // two-wire link pins
  input  wire logic        debug_clock_line,
  input  wire logic        debug_data_line_in,
  output logic             debug_data_line_out,
  output logic             debug_data_line_oe,
  // external bus request and grant
  input  wire logic        ext_bus_request,
  output logic             ext_bus_grant,
  // core halt
  output logic             core_halt,
  // debug register set, write space
  output logic             dbg_wr_strobe,
  output logic      [6:0]  dbg_wr_addr,
  output logic      [7:0]  dbg_wr_data,
  // debug register set, read space
  output logic             dbg_rd_strobe,
  output logic      [6:0]  dbg_rd_addr,
  input  wire logic [7:0]  dbg_rd_data
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0]  clk_sync;
    logic        clk_prev;
    logic [1:0]  dat_sync;
    logic        dat_prev;
    logic [1:0]  req_sync;
    tsdp_phase_t phase;
    logic [3:0]  cnt;
    logic [7:0]  shin;
    logic [7:0]  shout;
    logic [6:0]  addr;
    logic        sep_one;
    logic        oe;
    logic        dout;
    logic        grant;
    logic        permit;
    logic        halt;
    logic        wr_stb;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        rd_stb;
    logic [15:0] bytes;
    logic [15:0] starts;
    logic        ack;
    logic [31:0] rdata;
  } tsdp_state_t;

  tsdp_state_t s;
  tsdp_state_t next_s;

  // address step that sticks at the top of its space
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic [6:0] last);
    step_addr = (a == last) ? a : 7'(a + 7'h01);
  endfunction

  logic       clk_hi;
  logic       rise;
  logic       fall;
  logic       start;
  logic       bit_in;
  logic [7:0] byte_in;
  logic [7:0] rd_val;
  logic       bus_req;
  logic       idle;

  // ==========================================================================
  // link edge detection
  always_comb begin
    clk_hi = s.clk_sync[1] & s.clk_prev;
    rise   = s.clk_sync[1] & ~s.clk_prev;
    fall   = ~s.clk_sync[1] & s.clk_prev;
    // data may only move with the clock low, so a fall while high is start
    start  = clk_hi & s.dat_prev & ~s.dat_sync[1];
    bit_in = s.dat_sync[1];
    byte_in = {s.shin[6:0], bit_in};
    // the grant status lives inside the port itself
    rd_val = (s.addr == TSDP_BUS_STAT_ADDR) ? {7'h00, s.grant} : dbg_rd_data;
    bus_req = s.req_sync[1];
    idle    = (s.phase == PH_IDLE);
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.wr_stb = 1'b0;
    next_s.rd_stb = 1'b0;
    next_s.ack    = 1'b0;

    // first stage feeds only the second
    next_s.clk_sync = {s.clk_sync[0], debug_clock_line};
    next_s.clk_prev = s.clk_sync[1];
    next_s.dat_sync = {s.dat_sync[0], debug_data_line_in};
    next_s.dat_prev = s.dat_sync[1];
    next_s.req_sync = {s.req_sync[0], ext_bus_request};

    // a rising data edge with the clock high matches no branch below
    if (start) begin
      next_s.phase   = PH_ADDR;
      next_s.cnt     = 4'h0;
      next_s.oe      = 1'b0;
      next_s.sep_one = 1'b0;
      next_s.starts  = 16'(s.starts + 16'h0001);
    end else if (rise && !idle) begin
      if (s.cnt == TSDP_SEP_SLOT) begin
        // ninth clock: the separator, which only steers the grant
        next_s.sep_one = bit_in;
        next_s.cnt     = 4'h0;
      end else begin
        next_s.sep_one = 1'b0;
        next_s.shin    = byte_in;
        next_s.cnt     = 4'(s.cnt + 4'h1);
        if (s.cnt == TSDP_LAST_DATA) begin
          next_s.bytes = 16'(s.bytes + 16'h0001);
          case (s.phase)
            PH_ADDR: begin
              next_s.addr  = byte_in[7:1];
              next_s.phase = byte_in[0] ? PH_READ : PH_WRITE;
            end
            PH_WRITE: begin
              next_s.wr_stb  = 1'b1;
              next_s.wr_addr = s.addr;
              next_s.wr_data = byte_in;
              next_s.addr    = step_addr(s.addr, TSDP_WR_LAST_ADDR);
            end
            PH_READ: begin
              next_s.addr = step_addr(s.addr, TSDP_RD_LAST_ADDR);
            end
            default: begin
              next_s.phase = PH_IDLE;
            end
          endcase
        end
      end
    end else if (fall && s.phase == PH_READ) begin
      if (s.cnt == 4'h0) begin
        // first low phase after the separator: fetch and drive bit 7
        next_s.rd_stb = 1'b1;
        next_s.dout   = rd_val[7];
        next_s.shout  = {rd_val[6:0], 1'b0};
        next_s.oe     = 1'b1;
      end else if (s.cnt < TSDP_DATA_BITS) begin
        next_s.dout  = s.shout[7];
        next_s.shout = {s.shout[6:0], 1'b0};
      end else begin
        // separator slot belongs to the master
        next_s.oe = 1'b0;
      end
    end

    // grant is held while permit and the request stay; taken only at a safe point
    next_s.grant = s.permit & bus_req & (s.grant | idle | s.sep_one);

    // ------------------------------------------------------------------------
    // avalon slave: every access answers in its second cycle
    if ((avs_read | avs_write) && !s.ack) begin
      next_s.ack = 1'b1;
      case (avs_address)
        TSDP_OFS_CTRL: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rdata[TSDP_CTRL_PERMIT_BIT] = s.permit;
          next_s.rdata[TSDP_CTRL_HALT_BIT]   = s.halt;
        end
        TSDP_OFS_STATUS: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rdata[TSDP_ST_GRANT_BIT]  = s.grant;
          next_s.rdata[TSDP_ST_ACTIVE_BIT] = !idle;
          next_s.rdata[TSDP_ST_READ_BIT]   = (s.phase == PH_READ);
          next_s.rdata[TSDP_ST_SEP_BIT]    = s.sep_one;
          next_s.rdata[TSDP_ST_OE_BIT]     = s.oe;
          next_s.rdata[TSDP_ST_ADDR_LSB +: 7]  = s.addr;
          next_s.rdata[TSDP_ST_LASTW_LSB +: 8] = s.wr_data;
        end
        TSDP_OFS_ACTIV: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rdata[TSDP_ACT_BYTES_LSB +: 16] = s.bytes;
          next_s.rdata[TSDP_ACT_START_LSB +: 16] = s.starts;
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (avs_write && s.ack && avs_address == TSDP_OFS_CTRL && avs_byteenable[0]) begin
      next_s.permit = avs_writedata[TSDP_CTRL_PERMIT_BIT];
      // halting gates the core only; clocks and peripherals keep running
      next_s.halt   = avs_writedata[TSDP_CTRL_HALT_BIT];
      if (avs_writedata[TSDP_CTRL_CLEAR_BIT]) begin
        // a start in this same cycle still counts
        next_s.bytes  = 16'h0000;
        next_s.starts = start ? 16'h0001 : 16'h0000;
      end
      if (!avs_writedata[TSDP_CTRL_PERMIT_BIT]) begin
        next_s.grant = 1'b0;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      s          <= '0;
      // idle lines sit high, so edge history starts high to avoid a false edge
      s.clk_sync <= 2'h3;
      s.clk_prev <= 1'b1;
      s.dat_sync <= 2'h3;
      s.dat_prev <= 1'b1;
      s.phase    <= PH_IDLE;
      s.permit <= TSDP_RST_PERMIT;
      s.halt   <= TSDP_RST_HALT;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  always_comb begin
    avs_waitrequest     = (avs_read | avs_write) & ~s.ack;
    avs_readdata        = s.rdata;
    debug_data_line_out = s.dout;
    debug_data_line_oe  = s.oe;
    ext_bus_grant       = s.grant;
    core_halt           = s.halt;
    dbg_wr_strobe       = s.wr_stb;
    dbg_wr_addr         = s.wr_addr;
    dbg_wr_data         = s.wr_data;
    dbg_rd_strobe       = s.rd_stb;
    dbg_rd_addr         = s.addr;
  end

endmodule // tsdp_serial_debug_port

/* tsdp_link_master.sv */
// behavioural debug master that drives the two-wire link
`timescale 1ns/1ps
module tsdp_link_master (
  input  wire logic clock,
  input  wire logic out_bit,
  input  wire logic out_en,
  output logic      link_clk,
  output logic      link_data
);
  logic drv;
  logic en;
  // ==========
  // a released data line floats to its pull-up
  assign link_data = out_en ? out_bit : (en ? drv : 1'b1);
  initial begin
    link_clk = 1'b1;
    drv = 1'b1;
    en = 1'b0;
  end
  // four system clocks per half period keeps the link at clock/8
  task automatic half(input logic c);
    link_clk <= c;
    repeat (4) @(posedge clock);
  endtask
  // data moves one clock after the fall so no edge coincides with it
  task automatic bit_cell(input logic b, input logic e, output logic s);
    link_clk <= 1'b0;
    @(posedge clock);
    drv <= b;
    en <= e;
    repeat (3) @(posedge clock);
    half(1'b1);
    s = link_data;
  endtask
  // f=1 gives a start, f=0 a rising data edge with clock high
  task automatic start(input logic f);
    logic s;
    bit_cell(f, 1'b1, s);
    drv <= !f;
    half(1'b1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic sep, input logic rd,
                      output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cell(d[i], !rd, s);
      q[i] = s;
    end
    bit_cell(sep, 1'b1, s);
  endtask
endmodule // tsdp_link_master

/* tsdp_serial_debug_port_asserts.sv */
// concurrent checks on the serial debug port pins
`timescale 1ns/1ps
module tsdp_serial_debug_port_asserts
  import tsdp_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        debug_clock_line,
  input wire logic        debug_data_line_out,
  input wire logic        debug_data_line_oe,
  input wire logic        ext_bus_request,
  input wire logic        ext_bus_grant,
  input wire logic        core_halt,
  input wire logic        dbg_wr_strobe,
  input wire logic        dbg_rd_strobe
);
  logic take;
  logic permit;
  assign take = avs_write && !avs_waitrequest && avs_address == TSDP_OFS_CTRL
                && avs_byteenable[0];
  always_ff @(posedge clock) begin
    if (rst) begin
      permit <= TSDP_RST_PERMIT;
    end else if (take) begin
      permit <= avs_writedata[TSDP_CTRL_PERMIT_BIT];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // pin timing is judged two clocks back to allow for the synchronisers
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait");
  a_permit_gate: assert property (!permit && !$past(permit) |-> !ext_bus_grant)
    else $error("grant without permit");
  a_grant_cause: assert property ($rose(ext_bus_grant) |-> $past(ext_bus_request, 2) && permit)
    else $error("grant without request");
  a_halt_ctrl: assert property (take |=> core_halt == $past(avs_writedata[TSDP_CTRL_HALT_BIT]))
    else $error("halt not following control");
  a_oe_on_low: assert property ($rose(debug_data_line_oe) |-> !$past(debug_clock_line, 2))
    else $error("drive began with clock high");
  a_out_on_low: assert property (debug_data_line_oe && $changed(debug_data_line_out)
                                 |-> !$past(debug_clock_line, 2))
    else $error("data changed with clock high");
  a_rd_with_oe: assert property ($rose(debug_data_line_oe) |-> dbg_rd_strobe)
    else $error("drive without read load");
  a_wr_pulse: assert property (dbg_wr_strobe |=> !dbg_wr_strobe [*8])
    else $error("write strobes too close");
endmodule // tsdp_serial_debug_port_asserts

bind tsdp_serial_debug_port tsdp_serial_debug_port_asserts u_tsdp_serial_debug_port_asserts (
  .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .debug_clock_line, .debug_data_line_out, .debug_data_line_oe,
  .ext_bus_request, .ext_bus_grant, .core_halt, .dbg_wr_strobe, .dbg_rd_strobe);

/* tb_top.sv */
// self-checking bench for the two-wire serial debug port
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
  import tsdp_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, req = 1'b0;
  logic [3:0]  adr = 4'h0, be = 4'h1;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic        wait_n, lclk, ldat, dout, doe, grant, halt, wstb, rstb;
  logic [6:0]  waddr, raddr, a;
  logic [7:0]  wbyte, dat, q;
  logic [7:0]  wd[$];
  logic [6:0]  wa[$];
  int          miscompares = 0, comparisons = 0, cycles = 0;
  always #10 clock = ~clock;
  function automatic logic [7:0] rd_val(input logic [6:0] x);
    return {x, 1'b0} ^ 8'h5a;
  endfunction
  tsdp_serial_debug_port u_tsdp_serial_debug_port (.clock(clock), .rst(rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_n),
    .debug_clock_line(lclk), .debug_data_line_in(ldat), .debug_data_line_out(dout),
    .debug_data_line_oe(doe), .ext_bus_request(req), .ext_bus_grant(grant),
    .core_halt(halt), .dbg_wr_strobe(wstb), .dbg_wr_addr(waddr), .dbg_wr_data(wbyte),
    .dbg_rd_strobe(rstb), .dbg_rd_addr(raddr), .dbg_rd_data(rd_val(raddr)));
  tsdp_link_master u_tsdp_link_master (.clock(clock), .out_bit(dout), .out_en(doe),
    .link_clk(lclk), .link_data(ldat));
  always @(posedge clock) begin
    if (wstb === 1'b1) begin
      wa.push_back(waddr);
      wd.push_back(wbyte);
    end
  end
  task automatic av(input logic w, input logic [3:0] x, input logic [31:0] d,
                    output logic [31:0] v);
    adr <= x;
    wdat <= d;
    rd <= !w;
    wr <= w;
    // look between edges so the combinational wait is settled
    @(negedge clock);
    while (wait_n !== 1'b0) begin
      @(negedge clock);
    end
    v = rdat;
    @(posedge clock);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    void'($urandom(77107));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    // ==========
    // traffic before any start is ignored
    u_tsdp_link_master.start(1'b0);
    u_tsdp_link_master.xfer(8'h20, 1'b1, 1'b0, q);
    u_tsdp_link_master.xfer(8'h3c, 1'b1, 1'b0, q);
    av(1'b0, TSDP_OFS_ACTIV, 32'h0, r);
    `CHK("activity", 32'h0, r)
    `CHK("early_strobes", 0, wa.size())
    // ==========
    // block write running into the top of the write space
    a = 7'h2e;
    u_tsdp_link_master.start(1'b1);
    u_tsdp_link_master.xfer({a, 1'b0}, 1'b0, 1'b0, q);
    for (int i = 0; i < 4; i++) begin
      dat = 8'($urandom);
      u_tsdp_link_master.xfer(dat, i == 3, 1'b0, q);
      `CHK("wr_addr", a, wa.pop_front())
      `CHK("wr_data", dat, wd.pop_front())
      a = (a == TSDP_WR_LAST_ADDR) ? a : a + 7'h1;
    end
    // a write at 0x1f must not show up in the read space
    u_tsdp_link_master.start(1'b1);
    u_tsdp_link_master.xfer({7'h1f, 1'b0}, 1'b1, 1'b0, q);
    u_tsdp_link_master.xfer(~rd_val(7'h1f), 1'b1, 1'b0, q);
    `CHK("wr_single", 7'h1f, wa.pop_front())
    void'(wd.pop_front());
    // ==========
    // block read running into the top of the read space
    a = 7'h1f;
    u_tsdp_link_master.start(1'b1);
    u_tsdp_link_master.xfer({a, 1'b1}, 1'b0, 1'b0, q);
    for (int i = 0; i < 3; i++) begin
      u_tsdp_link_master.xfer(8'h00, i == 2, 1'b1, q);
      `CHK("rd_data", rd_val(a), q)
      a = (a == TSDP_RD_LAST_ADDR) ? a : a + 7'h1;
    end
    // ==========
    // grant: off after reset, withheld on zero separators
    req <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK("grant_reset", 1'b0, grant)
    u_tsdp_link_master.start(1'b1);
    u_tsdp_link_master.xfer({7'h10, 1'b0}, 1'b0, 1'b0, q);
    u_tsdp_link_master.xfer(8'($urandom), 1'b0, 1'b0, q);
    av(1'b1, TSDP_OFS_CTRL, 32'h1, r);
    repeat (8) @(posedge clock);
    `CHK("grant_sep0", 1'b0, grant)
    u_tsdp_link_master.xfer(8'($urandom), 1'b1, 1'b0, q);
    repeat (4) @(posedge clock);
    `CHK("grant_sep1", 1'b1, grant)
    av(1'b0, TSDP_OFS_STATUS, 32'h0, r);
    `CHK("grant_status", 1'b1, r[TSDP_ST_GRANT_BIT])
    av(1'b1, TSDP_OFS_CTRL, 32'h2, r);
    repeat (4) @(posedge clock);
    `CHK("grant_drop", 1'b0, grant)
    `CHK("halt", 1'b1, halt)
    av(1'b0, 4'hc, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    // a control write without its low byte lane is refused
    be <= 4'h0;
    av(1'b1, TSDP_OFS_CTRL, 32'h1, r);
    be <= 4'h1;
    av(1'b0, TSDP_OFS_CTRL, 32'h0, r);
    `CHK("ctrl_be0", 32'h2, r)
    summarize();
  end
endmodule // tb_top
